// ---- core/gpm_regs.svh ----
// register offsets, field positions and fixed values of the graphics pm header
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH
`define GPM_OFF_IRQ_PIN 8'h3d
`define GPM_OFF_BURST_GNT 8'h3e
`define GPM_OFF_ACC_LAT 8'h3f
`define GPM_OFF_PM_HDR 8'hd0
`define GPM_OFF_PM_CAP 8'hd2
`define GPM_OFF_PM_CTL 8'hd4
`define GPM_IRQ_PIN_VAL 8'h01
`define GPM_BURST_GNT_VAL 8'h00
`define GPM_ACC_LAT_VAL 8'h00
`define GPM_CAPABILITY_IDENTIFIER_VAL 8'h01
`define GPM_NEXT_CAPABILITY_POINTER_VAL 8'h00
`define GPM_WAKE_SUP_VAL 5'h00
`define GPM_RSVD3_VAL 3'h0
`define GPM_VERSION_VAL 3'h1
`define GPM_PM_CAP_RESET 16'h0021
`define GPM_PM_CTL_RESET 16'h0000
`define GPM_DATA_SEL_VAL 4'h0
`define GPM_DATA_SCL_VAL 2'h0
`define GPM_RSVD6_VAL 6'h00
`define GPM_LEVEL_MSB 1
`define GPM_LEVEL_LSB 0
`endif

// ---- core/gpm_pkg.sv ----
// types shared by the graphics pm configuration registers
package gpm_pkg;
	typedef enum logic [1:0] {
		GPM_LEVEL_D0 = 2'h0,
		GPM_LEVEL_D1 = 2'h1,
		GPM_LEVEL_D2 = 2'h2,
		GPM_LEVEL_D3 = 2'h3
	} gpm_level_t;
endpackage

// ---- core/gpm_config_regs.sv ----
// configuration header and power management registers of the graphics function
//
// Notes on behaviour
// [RULE1] interrupt pin byte always reads 01h, first legacy interrupt line
// [RULE2] burst grant hint byte always reads 00h
// [RULE3] access latency hint byte always reads 00h
// [RULE4] capability identifier byte reads 01h, power management
// [RULE5] next capability pointer reads 00h, last list entry
// [RULE6] wake support field and wake clock bit read zero
// [RULE7] D1 and D2 support bits read zero
// [RULE8] device specific initialisation bit reads one
// [RULE9] version reads 001b; auxiliary power bit reads zero
// [RULE10] capability bits 8:6 read zero
// [RULE11] wake_event_status and wake_event_enable are fixed zero
// [RULE12] data scale and data select fields read zero
// [RULE13] control bits 7:2 read zero, writes ignored
// [RULE14] device_power_level holds state, writable, resets to D0; 11 is D3
// [RULE15] unsupported level write completes normally, data discarded
// [RULE16] D1 or D2 writes blocked, previous value kept
`include "gpm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module gpm_config_regs
	import gpm_pkg::*;
#(
	parameter int DATA_W = 32
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [DATA_W-1:0] cfg_wdata,
	output logic [DATA_W-1:0] cfg_rdata,
	output logic cfg_ack,
	output gpm_pkg::gpm_level_t device_power_level
);
	import gpm_pkg::*;

	if (DATA_W != 32)
	begin : g_width_check
		$error("gpm_config_regs serves 32-bit configuration data only");
	end

	// dword index of a byte offset
	function automatic logic [5:0] dword_of(input logic [7:0] a);
		dword_of = a[7:2];
	endfunction

	function automatic logic level_supported(input logic [1:0] v);
		level_supported = (v == GPM_LEVEL_D0) || (v == GPM_LEVEL_D3);
	endfunction

	// dword indices used by the checks below
	localparam logic [5:0] DW_IRQ = dword_of(`GPM_OFF_IRQ_PIN);
	localparam logic [5:0] DW_HDR = dword_of(`GPM_OFF_PM_HDR);
	localparam logic [5:0] DW_CTL = dword_of(`GPM_OFF_PM_CTL);

	logic [15:0] pm_header;
	logic [15:0] pm_caps;
	logic [15:0] pm_ctl;
	logic [DATA_W-1:0] next_rdata;
	logic level_wr;

	assign pm_header = {
		`GPM_NEXT_CAPABILITY_POINTER_VAL, // [RULE5]
		`GPM_CAPABILITY_IDENTIFIER_VAL // [RULE4]
	};

	// wake, d2, d1, reserved, dsi, aux, wake clock, version
	assign pm_caps = {
		`GPM_WAKE_SUP_VAL, // [RULE6]
		1'b0, // [RULE7]
		1'b0, // [RULE7]
		`GPM_RSVD3_VAL, // [RULE10]
		1'b1, // [RULE8]
		1'b0, // [RULE9]
		1'b0, // [RULE6]
		`GPM_VERSION_VAL // [RULE9]
	};

	assign pm_ctl = {
		1'b0, // [RULE11]
		`GPM_DATA_SCL_VAL, // [RULE12]
		`GPM_DATA_SEL_VAL, // [RULE12]
		1'b0, // [RULE11]
		`GPM_RSVD6_VAL, // [RULE13]
		device_power_level // [RULE14]
	};

	always_comb
	begin
		next_rdata = '0;
		if (dword_of(cfg_addr) == dword_of(`GPM_OFF_IRQ_PIN))
		begin
			// byte 0 is the interrupt line register, not held here
			next_rdata = {
				`GPM_ACC_LAT_VAL, // [RULE3]
				`GPM_BURST_GNT_VAL, // [RULE2]
				`GPM_IRQ_PIN_VAL, // [RULE1]
				8'h00
			};
		end
		else if (dword_of(cfg_addr) == dword_of(`GPM_OFF_PM_HDR))
		begin
			next_rdata = {pm_caps, pm_header};
		end
		else if (dword_of(cfg_addr) == dword_of(`GPM_OFF_PM_CTL))
		begin
			next_rdata = {16'h0000, pm_ctl};
		end
	end

	// only the low byte lane of the control dword holds a writable field
	assign level_wr = cfg_wr && cfg_be[0] && (dword_of(cfg_addr) == dword_of(`GPM_OFF_PM_CTL));

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			device_power_level <= GPM_LEVEL_D0; // [RULE14]
		end
		else if (level_wr && level_supported(cfg_wdata[`GPM_LEVEL_MSB:`GPM_LEVEL_LSB])) // [RULE15] [RULE16]
		begin
			device_power_level <= gpm_level_t'(cfg_wdata[`GPM_LEVEL_MSB:`GPM_LEVEL_LSB]); // [RULE14]
		end
	end

	// every access answers one cycle later, accepted or not
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_ack <= 1'b0;
		end
		else
		begin
			cfg_ack <= cfg_rd || cfg_wr; // [RULE15]
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_rdata <= '0;
		end
		else if (cfg_rd)
		begin
			cfg_rdata <= next_rdata;
		end
	end

	property p_irq_dword;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_addr[7:2] == 6'h0f) |=> (cfg_rdata[15:8] == 8'h01);
	endproperty
	a_irq_dword: assert property (p_irq_dword) else $error("interrupt pin byte not 01h"); // [RULE1]

	property p_grant_latency;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_addr[7:2] == 6'h0f) |=> (cfg_rdata[31:16] == 16'h0000);
	endproperty
	a_grant_latency: assert property (p_grant_latency) else $error("grant or latency byte not zero"); // [RULE2] [RULE3]

	property p_cap_header;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_addr == 8'hd0) ##1 cfg_ack |-> (cfg_rdata[15:0] == 16'h0001);
	endproperty
	a_cap_header: assert property (p_cap_header) else $error("capability header wrong"); // [RULE4] [RULE5]

	property p_cap_bits;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_addr[7:2] == 6'h34) |=> (cfg_rdata[31:16] == 16'h0021);
	endproperty
	a_cap_bits: assert property (p_cap_bits) else $error("capabilities word not 0021h"); // [RULE6] [RULE7] [RULE8] [RULE9] [RULE10]

	property p_ctl_fixed;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_addr[7:2] == 6'h35) |=> (cfg_rdata[31:2] == 30'h0);
	endproperty
	a_ctl_fixed: assert property (p_ctl_fixed) else $error("fixed control bits not zero"); // [RULE11] [RULE12] [RULE13]

	property p_ctl_level_read;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && !cfg_wr && cfg_addr[7:2] == 6'h35) |=> (cfg_rdata[1:0] == $past(device_power_level));
	endproperty
	a_ctl_level_read: assert property (p_ctl_level_read) else $error("level read mismatch"); // [RULE14]

	property p_level_takes;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_wr && cfg_be[0] && cfg_addr[7:2] == 6'h35 && (cfg_wdata[1:0] == 2'h0 || cfg_wdata[1:0] == 2'h3))
		|=> (device_power_level == $past(cfg_wdata[1:0]));
	endproperty
	a_level_takes: assert property (p_level_takes) else $error("supported level not taken"); // [RULE14]

	property p_level_blocked;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_wr && cfg_addr[7:2] == 6'h35 && (cfg_wdata[1:0] == 2'h1 || cfg_wdata[1:0] == 2'h2))
		|=> $stable(device_power_level);
	endproperty
	a_level_blocked: assert property (p_level_blocked) else $error("unsupported level accepted"); // [RULE16]

	property p_write_acked;
		@(posedge sys_clk) disable iff (!resetn)
		cfg_wr |=> cfg_ack ##1 (!cfg_ack || $past(cfg_rd || cfg_wr));
	endproperty
	a_write_acked: assert property (p_write_acked) else $error("write not completed"); // [RULE15]

	property p_level_only_by_write;
		@(posedge sys_clk) disable iff (!resetn)
		!$stable(device_power_level) |-> $past(level_wr);
	endproperty
	a_level_only_by_write: assert property (p_level_only_by_write) else $error("level changed without write"); // [RULE13] [RULE14]

	property p_level_d1_d2_never;
		@(posedge sys_clk) disable iff (!resetn)
		(device_power_level == GPM_LEVEL_D0) || (device_power_level == GPM_LEVEL_D3);
	endproperty
	a_level_d1_d2_never: assert property (p_level_d1_d2_never) else $error("level holds D1 or D2"); // [RULE16]

	property p_ack_only_after_req;
		@(posedge sys_clk) disable iff (!resetn)
		cfg_ack |-> $past(cfg_rd || cfg_wr);
	endproperty
	a_ack_only_after_req: assert property (p_ack_only_after_req) else $error("ack without request"); // [RULE15]

	property p_ack_low_idle;
		@(posedge sys_clk) disable iff (!resetn)
		(!cfg_rd && !cfg_wr) |=> !cfg_ack;
	endproperty
	a_ack_low_idle: assert property (p_ack_low_idle) else $error("ack held without request"); // [RULE15]

	property p_read_acked;
		@(posedge sys_clk) disable iff (!resetn)
		cfg_rd |=> cfg_ack;
	endproperty
	a_read_acked: assert property (p_read_acked) else $error("read not completed"); // [RULE15]

	property p_rdata_holds;
		@(posedge sys_clk) disable iff (!resetn)
		!cfg_rd |=> $stable(cfg_rdata);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read"); // [RULE14]

	property p_unmapped_zero;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_addr[7:2] != DW_IRQ && cfg_addr[7:2] != DW_HDR && cfg_addr[7:2] != DW_CTL)
		|=> (cfg_rdata == '0);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // [RULE15]

	property p_irq_line_byte;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_addr[7:2] == DW_IRQ) |=> (cfg_rdata[7:0] == 8'h00);
	endproperty
	a_irq_line_byte: assert property (p_irq_line_byte) else $error("interrupt line byte not zero"); // [RULE1]

	property p_level_no_lane;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_wr && !cfg_be[0]) |=> $stable(device_power_level);
	endproperty
	a_level_no_lane: assert property (p_level_no_lane) else $error("level moved without its byte lane"); // [RULE13]

	property p_level_other_dword;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_wr && cfg_addr[7:2] != DW_CTL) |=> $stable(device_power_level);
	endproperty
	a_level_other_dword: assert property (p_level_other_dword) else $error("level moved by other write"); // [RULE15]

	property p_read_with_write;
		@(posedge sys_clk) disable iff (!resetn)
		(cfg_rd && cfg_wr && cfg_addr[7:2] == DW_CTL) |=> (cfg_rdata[1:0] == $past(device_power_level));
	endproperty
	a_read_with_write: assert property (p_read_with_write) else $error("read beside write not old level"); // [RULE14]

	c_rd_unmapped: cover property (@(posedge sys_clk) disable iff (!resetn)
		cfg_rd && cfg_addr[7:2] != DW_IRQ && cfg_addr[7:2] != DW_HDR && cfg_addr[7:2] != DW_CTL);
	c_enter_d3: cover property (@(posedge sys_clk) disable iff (!resetn)
		device_power_level == GPM_LEVEL_D0 ##1 device_power_level == GPM_LEVEL_D3);
	c_back_d0: cover property (@(posedge sys_clk) disable iff (!resetn)
		device_power_level == GPM_LEVEL_D3 ##1 device_power_level == GPM_LEVEL_D0);
	c_blocked_write: cover property (@(posedge sys_clk) disable iff (!resetn)
		cfg_wr && cfg_addr[7:2] == 6'h35 && cfg_wdata[1:0] == 2'h2);
	c_cap_read: cover property (@(posedge sys_clk) disable iff (!resetn)
		cfg_rd && cfg_addr[7:2] == 6'h34);
endmodule
`default_nettype wire

// ---- tb/gpm_host_model.sv ----
// host bridge model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module gpm_host_model
(
	input wire logic sys_clk,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata,
	output logic cfg_rd,
	output logic cfg_wr,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata
);
	initial
	begin
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	// one-cycle request pulse, then wait for the ack under a bound
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		@(negedge sys_clk);
		cfg_rd <= !wr;
		cfg_wr <= wr;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		@(negedge sys_clk);
		cfg_rd <= 1'b0;
		cfg_wr <= 1'b0;
		// released lines show a changed value
		cfg_addr <= ~a;
		cfg_be <= ~be;
		cfg_wdata <= ~d;
		n = 0;
		while (cfg_ack !== 1'b1 && n < 4)
		begin
			@(negedge sys_clk);
			n++;
		end
		ok = (cfg_ack === 1'b1) && (n == 0);
		q = cfg_rdata;
	endtask
endmodule
`default_nettype wire

// ---- tb/gpm_config_regs_test.sv ----
// self-checking bench of the graphics pm configuration registers
`timescale 1ns/1ps
`default_nettype none
module gpm_config_regs_test;
	import gpm_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic cfg_rd, cfg_wr, cfg_ack;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, q;
	logic ok;
	gpm_level_t device_power_level;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	localparam logic [3:0] wbe [8] = '{4'hf, 4'hf, 4'hf, 4'he, 4'h1, 4'h1, 4'h1, 4'h1};
	localparam logic [31:0] wd [8] = '{32'hffffffff, 32'hfffffffd, 32'h2, 32'h0, 32'h0, 32'h1, 32'h2, 32'h3};
	localparam logic [1:0] wl [8] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3};
	always #12.5 sys_clk = ~sys_clk;
	gpm_config_regs #(.DATA_W(32)) dut (.sys_clk(sys_clk), .resetn(resetn), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
		.device_power_level(device_power_level));
	gpm_host_model host (.sys_clk(sys_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_rd(cfg_rd),
		.cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 4'hf, 32'h0, q, ok);
		check({31'h0, ok}, 32'h1, "read ack");
		check(q, exp, "read data");
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		host.xfer(1'b1, a, be, d, q, ok);
		check({31'h0, ok}, 32'h1, "write ack");
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			final_report;
		end
	end
	initial
	begin
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		check({30'h0, device_power_level}, 32'h0, "reset level");
		rd(8'h3c, 32'h00000100);
		rd(8'hd0, 32'h00210001);
		rd(8'hd4, 32'h0);
		wr(8'h3c, 4'hf, 32'hffffffff);
		wr(8'hd0, 4'hf, 32'hffffffff);
		rd(8'h3c, 32'h00000100);
		rd(8'hd0, 32'h00210001);
		rd(8'h80, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			wr(8'hd4, wbe[i], wd[i]);
			check({30'h0, device_power_level}, {30'h0, wl[i]}, "level port");
			rd(8'hd4, {30'h0, wl[i]});
		end
		@(negedge sys_clk);
		resetn = 1'b0;
		@(negedge sys_clk);
		check({30'h0, device_power_level}, 32'h0, "level in reset");
		resetn = 1'b1;
		rd(8'hd4, 32'h0);
		final_report;
	end
endmodule
`default_nettype wire
